/* File: rtl/swb_top.v */
// sleep wake-up on pin change and brown-out reset control
// assumes the core pulses sleep_req on the sleep instruction, pins and the
// supply comparator are asynchronous, and nrst is the power-on reset
//
// Added by the designer: the Avalon-MM slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "swb_map.vh"

module swb_top #(
	parameter WARM_RST_CYC = `SWB_WARM_RST_CYC,
	parameter FILT_CYC     = `SWB_FILT_CYC
) (
	input  wire        clock,
	input  wire        nrst,
	input  wire [7:0]  high_voltage_port,
	input  wire        external_reset_pin_n,
	input  wire        supply_low,
	input  wire        sleep_req,
	output wire        core_reset_n,
	output wire        sleeping,
	output wire        brownout_monitor_en,
	output wire        brownout_trip_sel,
	output wire        irq,
	input  wire [4:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output wire [31:0] avs_readdata,
	output wire        avs_waitrequest
);

localparam NPIN = 7;
localparam NWK  = 5;

////////////////////////////////////////////////////////////////////////////////
// pin conditioning: wake bits 0..3 and 7, external reset, supply comparator

wire [NPIN-1:0] pin_raw;
wire [NPIN-1:0] pin_flt;
wire [NWK-1:0]  wake_lvl;
wire            ext_rst_flt_n;
wire            supply_low_flt;

assign pin_raw = {supply_low, external_reset_pin_n, high_voltage_port[7],
	high_voltage_port[3:0]};

genvar gi;
generate
	for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_pin
		swb_filt #(
			.FILT_CYC (FILT_CYC),
			.CW       (16),
			.RST_VAL  (1'b0)
		) u_filt (
			.clock     (clock),
			.nrst      (nrst),
			.pin_in    (pin_raw[gi]),
			.level_out (pin_flt[gi])
		);
	end
endgenerate

// the filter gives glitch insensitivity and lets bit 7 rise slowly
assign wake_lvl       = pin_flt[4:0];
assign ext_rst_flt_n  = pin_flt[5];
assign supply_low_flt = pin_flt[6];

////////////////////////////////////////////////////////////////////////////////
// register state

reg  [7:0]      cfg_ff;
reg  [7:0]      nxt_cfg;
reg             pin_change_wake_flag_ff;
reg             nxt_pin_change_wake_flag;
reg             unlock_ff;
reg             nxt_unlock;
reg  [1:0]      irq_stat_ff;
reg  [1:0]      nxt_irq_stat;
reg  [1:0]      irq_mask_ff;
reg  [1:0]      nxt_irq_mask;
reg             sleep_ff;
reg             nxt_sleep;
reg  [NWK-1:0]  ref_ff;
reg  [NWK-1:0]  nxt_ref;
reg  [15:0]     warm_cnt_ff;
reg  [15:0]     nxt_warm_cnt;
reg             bo_hold_d_ff;
reg             core_rst_n_ff;
reg             ack_ff;
reg  [31:0]     rdata_ff;
reg  [31:0]     nxt_rdata;

wire            bod_en;
wire            wake_en;
wire            wake_armed;
wire            wake_hit;
wire            bo_hold;
wire            bo_event;
wire            any_core_rst;
wire            bus_req;
wire            wr_take;
wire            rd_take;
wire            be0;

assign bod_en  = ~cfg_ff[`SWB_CFG_BOD_EN_N];
assign wake_en = cfg_ff[`SWB_CFG_WAKE_EN];

////////////////////////////////////////////////////////////////////////////////
// avalon slave: one wait cycle, then the answer; read data stand with ack

assign bus_req         = avs_read | avs_write;
assign avs_waitrequest = bus_req & ~ack_ff;
assign wr_take         = avs_write & ack_ff;
assign rd_take         = avs_read & ack_ff;
assign be0             = avs_byteenable[0];
assign avs_readdata    = rdata_ff;

always @* begin
	nxt_rdata = 32'h00000000;
	case (avs_address)
		`SWB_OFS_CFG2: begin
			nxt_rdata[7:0] = cfg_ff;
		end
		`SWB_OFS_STATUS: begin
			nxt_rdata[`SWB_ST_PIN_CHANGE_WAKE_FLAG]    = pin_change_wake_flag_ff;
			nxt_rdata[`SWB_ST_SLEEP]    = sleep_ff;
			nxt_rdata[`SWB_ST_BO_LOW]   = supply_low_flt;
			nxt_rdata[`SWB_ST_UNLOCKED] = unlock_ff;
		end
		`SWB_OFS_IRQ_STAT: begin
			nxt_rdata[1:0] = irq_stat_ff;
		end
		`SWB_OFS_IRQ_MASK: begin
			nxt_rdata[1:0] = irq_mask_ff;
		end
		default: begin
			nxt_rdata = 32'h00000000;
		end
	endcase
end

////////////////////////////////////////////////////////////////////////////////
// sleep, wake and reset sequencing

assign wake_armed   = sleep_ff & wake_en;
assign wake_hit     = wake_armed & (|(wake_lvl ^ ref_ff));
assign bo_hold      = bod_en & supply_low_flt;
assign bo_event     = bo_hold & ~bo_hold_d_ff;
assign any_core_rst = ~ext_rst_flt_n | bo_hold | (warm_cnt_ff != 16'h0000);

always @* begin
	nxt_sleep    = sleep_ff;
	nxt_ref      = ref_ff;
	nxt_warm_cnt = warm_cnt_ff;
	nxt_pin_change_wake_flag    = pin_change_wake_flag_ff;
	if (warm_cnt_ff != 16'h0000) begin
		nxt_warm_cnt = warm_cnt_ff - 16'h0001;
	end
	if (wake_hit) begin
		// warm reset: core held for a fixed time, config is kept
		nxt_warm_cnt = WARM_RST_CYC[15:0];
		nxt_sleep    = 1'b0;
		nxt_pin_change_wake_flag    = 1'b0;
	end else if (any_core_rst) begin
		nxt_sleep = 1'b0;
	end else if (sleep_req & ~sleep_ff) begin
		nxt_sleep = 1'b1;
		nxt_ref   = wake_lvl;
	end
	// software sets the flag back by writing one; a wake in the same
	// cycle still wins
	if (wr_take && be0 && avs_address == `SWB_OFS_STATUS && !wake_hit &&
		avs_writedata[`SWB_ST_PIN_CHANGE_WAKE_FLAG]) begin
		nxt_pin_change_wake_flag = 1'b1;
	end
end

////////////////////////////////////////////////////////////////////////////////
// config, interlock, interrupts

always @* begin
	nxt_cfg      = cfg_ff;
	nxt_unlock   = unlock_ff;
	nxt_irq_mask = irq_mask_ff;
	nxt_irq_stat = irq_stat_ff;
	if (wr_take && be0) begin
		case (avs_address)
			`SWB_OFS_CFG2: begin
				nxt_cfg[`SWB_CFG_BOD_EN_N] = avs_writedata[`SWB_CFG_BOD_EN_N];
				nxt_cfg[`SWB_CFG_WAKE_EN]  = avs_writedata[`SWB_CFG_WAKE_EN];
				// trip level moves only when unlocked and the detector is
				// off, so a change can never fire a false brown-out
				if (unlock_ff && cfg_ff[`SWB_CFG_BOD_EN_N] &&
					avs_writedata[`SWB_CFG_BOD_EN_N]) begin
					nxt_cfg[`SWB_CFG_TRIP_SEL] = avs_writedata[`SWB_CFG_TRIP_SEL];
				end
				nxt_unlock = 1'b0;
			end
			`SWB_OFS_UNLOCK: begin
				nxt_unlock = (avs_writedata[7:0] == `SWB_UNLOCK_KEY);
			end
			`SWB_OFS_IRQ_MASK: begin
				nxt_irq_mask = avs_writedata[1:0];
			end
			default: begin
				nxt_unlock = unlock_ff;
			end
		endcase
	end
	if (rd_take && avs_address == `SWB_OFS_IRQ_STAT) begin
		nxt_irq_stat = 2'b00;
	end
	// events set after the read clear so a coincident event is kept
	if (wake_hit) begin
		nxt_irq_stat[`SWB_IRQ_WAKE] = 1'b1;
	end
	if (bo_event) begin
		nxt_irq_stat[`SWB_IRQ_BROWNOUT] = 1'b1;
	end
end

always @(posedge clock or negedge nrst) begin
	if (!nrst) begin
		cfg_ff        <= `SWB_CFG_RST;
		pin_change_wake_flag_ff      <= `SWB_PIN_CHANGE_WAKE_FLAG_RST;
		unlock_ff     <= 1'b0;
		irq_stat_ff   <= `SWB_IRQ_RST;
		irq_mask_ff   <= `SWB_IRQ_RST;
		sleep_ff      <= 1'b0;
		ref_ff        <= {NWK{1'b0}};
		warm_cnt_ff   <= 16'h0000;
		bo_hold_d_ff  <= 1'b0;
		core_rst_n_ff <= 1'b0;
		ack_ff        <= 1'b0;
		rdata_ff      <= 32'h00000000;
	end else begin
		cfg_ff        <= nxt_cfg;
		pin_change_wake_flag_ff      <= nxt_pin_change_wake_flag;
		unlock_ff     <= nxt_unlock;
		irq_stat_ff   <= nxt_irq_stat;
		irq_mask_ff   <= nxt_irq_mask;
		sleep_ff      <= nxt_sleep;
		ref_ff        <= nxt_ref;
		warm_cnt_ff   <= nxt_warm_cnt;
		bo_hold_d_ff  <= bo_hold;
		core_rst_n_ff <= ~any_core_rst;
		ack_ff        <= bus_req & ~ack_ff;
		if (bus_req & ~ack_ff) begin
			rdata_ff <= nxt_rdata;
		end
	end
end

assign core_reset_n        = core_rst_n_ff;
assign sleeping            = sleep_ff;
assign brownout_monitor_en = bod_en;
assign brownout_trip_sel   = cfg_ff[`SWB_CFG_TRIP_SEL];
assign irq                 = |(irq_stat_ff & irq_mask_ff);

endmodule
`default_nettype wire

/* File: rtl/swb_map.vh */
// constants for the sleep-wake and brown-out reset block
// assumes a 100 MHz core clock and a 32-bit avalon-mm register slave
//
// Summary of operation
// - on sleep entry, latch all five wake inputs as reference levels
// - in sleep, an opposite stable level on a wake input gives a warm reset
// - a pin-change reset clears the pin-change wake flag to zero
// - one enable bit in the second config register gates all five wake inputs
// - port bit seven is also a wake input, tolerant of slow rising edges
// - a wake from bit seven uses the same pin-change wake flag
// - enabled brown-out with low supply holds the core in reset while low
// - brown-out comes up disabled; writing zero to its active-low enable arms it
// - software picks one of two trip levels, guarded by interlocks
`ifndef SWB_MAP_VH
`define SWB_MAP_VH

// register byte offsets
`define SWB_OFS_CFG2       5'h00
`define SWB_OFS_STATUS     5'h04
`define SWB_OFS_IRQ_STAT   5'h08
`define SWB_OFS_IRQ_MASK   5'h0C
`define SWB_OFS_UNLOCK     5'h10

// second_config_register fields
`define SWB_CFG_BOD_EN_N   0
`define SWB_CFG_TRIP_SEL   1
`define SWB_CFG_WAKE_EN    4
`define SWB_CFG_RST        8'h01

// status fields
`define SWB_ST_PIN_CHANGE_WAKE_FLAG       0
`define SWB_ST_SLEEP       1
`define SWB_ST_BO_LOW      2
`define SWB_ST_UNLOCKED    3
`define SWB_PIN_CHANGE_WAKE_FLAG_RST      1'b1

// interrupt fields
`define SWB_IRQ_WAKE       0
`define SWB_IRQ_BROWNOUT   1
`define SWB_IRQ_RST        2'h0

// key that opens the trip-level interlock for one write
`define SWB_UNLOCK_KEY     8'hA5

// timing
`define SWB_CLK_PERIOD_NS  10
`define SWB_WARM_RST_NS    1000
`define SWB_WARM_RST_CYC   ((`SWB_WARM_RST_NS + `SWB_CLK_PERIOD_NS - 1) / `SWB_CLK_PERIOD_NS)
`define SWB_FILT_NS        200
`define SWB_FILT_CYC       ((`SWB_FILT_NS + `SWB_CLK_PERIOD_NS - 1) / `SWB_CLK_PERIOD_NS)

`endif

/* File: rtl/swb_filt.v */
// two-flop synchroniser followed by a stability filter for one pin
// assumes the pin is asynchronous to clock; output changes only after a
// level has held for FILT_CYC cycles
`timescale 1ns/10ps
`default_nettype none

module swb_filt #(
	parameter       FILT_CYC = 20,
	parameter       CW       = 8,
	parameter [0:0] RST_VAL  = 1'b0
) (
	input  wire       clock,
	input  wire       nrst,
	input  wire       pin_in,
	output wire       level_out
);

reg          sync1_ff;
reg          sync2_ff;
reg          level_ff;
reg [CW-1:0] cnt_ff;

////////////////////////////////////////////////////////////////////////////////
// a slow edge may chatter near threshold; the counter restarts on every
// bounce so only a settled level passes
always @(posedge clock or negedge nrst) begin
	if (!nrst) begin
		sync1_ff <= RST_VAL;
		sync2_ff <= RST_VAL;
		level_ff <= RST_VAL;
		cnt_ff   <= {CW{1'b0}};
	end else begin
		sync1_ff <= pin_in;
		sync2_ff <= sync1_ff;
		if (sync2_ff == level_ff) begin
			cnt_ff <= {CW{1'b0}};
		end else if (cnt_ff == FILT_CYC[CW-1:0] - 1'b1) begin
			level_ff <= sync2_ff;
			cnt_ff   <= {CW{1'b0}};
		end else begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end
end

assign level_out = level_ff;

endmodule
`default_nettype wire

/* File: verif/swb_top_sva.sv */
// port-level checks for swb_top
// assumes one clock domain with nrst as its only reset
`timescale 1ns/10ps
`default_nettype none
module swb_chk #(
	parameter WARM_RST_CYC = 100,
	parameter FILT_CYC     = 20
) (
	input wire logic        clock,
	input wire logic        nrst,
	input wire logic        external_reset_pin_n,
	input wire logic        supply_low,
	input wire logic        sleep_req,
	input wire logic        core_reset_n,
	input wire logic        sleeping,
	input wire logic        brownout_monitor_en,
	input wire logic        brownout_trip_sel,
	input wire logic [4:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic        avs_waitrequest
);
	logic [15:0] warm_ff;
	logic [7:0]  low_ff;
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	////////////////////////////////////////////////////////////////////////////
	// cycles left of a warm reset, and cycles of enabled low supply
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			warm_ff <= 16'h0;
			low_ff <= 8'h0;
		end else begin
			warm_ff <= ($fell(sleeping) && core_reset_n) ? 16'(WARM_RST_CYC) :
				warm_ff - 16'(warm_ff != 16'h0);
			low_ff <= (supply_low && brownout_monitor_en) ? low_ff + 8'(low_ff != 8'hFF) : 8'h0;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	sequence acc_s;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence cfg_wr_s;
		avs_write && !avs_waitrequest && avs_address == 5'h00 && avs_byteenable[0];
	endsequence
	sequence wake_s;
		sleeping && core_reset_n ##1 !sleeping;
	endsequence
	AST_ONE_WAIT: assert property (acc_s |=> !avs_waitrequest)
		else $error("bus answer not after one wait");
	AST_SLEEP_ENTER: assert property (sleep_req && !sleeping && core_reset_n |=> sleeping)
		else $error("sleep not entered");
	AST_WAKE_RESET: assert property (wake_s |=> !core_reset_n)
		else $error("wake without warm reset");
	AST_WARM_HOLD: assert property (warm_ff != 16'h0 |-> !core_reset_n)
		else $error("warm reset too short");
	AST_BOD_HOLD: assert property (low_ff > 8'(FILT_CYC + 6) |-> !core_reset_n)
		else $error("low supply does not hold reset");
	AST_BOD_EN: assert property (cfg_wr_s |=> brownout_monitor_en == !$past(avs_writedata[0]))
		else $error("detector enable not as written");
	AST_TRIP_GUARD: assert property ($changed(brownout_trip_sel) |-> !brownout_monitor_en
		&& $past(avs_write && !avs_waitrequest && avs_address == 5'h00 && !brownout_monitor_en))
		else $error("trip level changed unguarded");
	AST_AWAKE_QUIET: assert property (!sleeping && !$past(sleeping) && core_reset_n
		&& !brownout_monitor_en && !$past(brownout_monitor_en)
		&& external_reset_pin_n && $past(external_reset_pin_n) |=> core_reset_n)
		else $error("reset while awake");
endmodule
bind swb_top swb_chk #(.WARM_RST_CYC(WARM_RST_CYC), .FILT_CYC(FILT_CYC)) u_chk (
	.clock(clock), .nrst(nrst), .external_reset_pin_n(external_reset_pin_n),
	.supply_low(supply_low), .sleep_req(sleep_req), .core_reset_n(core_reset_n),
	.sleeping(sleeping), .brownout_monitor_en(brownout_monitor_en),
	.brownout_trip_sel(brownout_trip_sel), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_waitrequest(avs_waitrequest));
`default_nettype wire

/* File: verif/swb_core_model.sv */
// core model that issues the sleep pulse
// assumes go_sleep is a level request from the bench
`timescale 1ns/10ps
`default_nettype none
module swb_core_model (
	input  wire logic clock,
	input  wire logic nrst,
	input  wire logic go_sleep,
	input  wire logic core_reset_n,
	input  wire logic sleeping,
	output logic      sleep_req
);
	// a core in reset or asleep runs no instruction, so no pulse then
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			sleep_req <= 1'b0;
		end else begin
			sleep_req <= go_sleep && core_reset_n && !sleeping && !sleep_req;
		end
	end
endmodule
`default_nettype wire

/* File: verif/sleep_wake_and_brownout_reset_test.sv */
// self-checking bench for swb_top
// assumes swb_chk is bound and swb_core_model gives the sleep pulse
`timescale 1ns/10ps
`default_nettype none
module sleep_wake_and_brownout_reset_test;
	localparam W = 4;
	localparam F = 3;
	logic        clock = 1'b0;
	logic        nrst = 1'b0;
	logic [7:0]  hv = 8'h00;
	logic        ext_n = 1'b1;
	logic        supply_low = 1'b0;
	logic        go_sleep = 1'b0;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'hF;
	logic [31:0] rd;
	integer      error_cnt = 0, n_compared = 0, seed = 32'h0220b521, i, p, n;
	wire         sleep_req, core_reset_n, sleeping, bod_en, trip, irq, avs_waitrequest;
	wire [31:0]  avs_readdata;
	always #5 clock = ~clock;
	swb_top #(.WARM_RST_CYC(W), .FILT_CYC(F)) dut (.clock(clock), .nrst(nrst),
		.high_voltage_port(hv), .external_reset_pin_n(ext_n), .supply_low(supply_low),
		.sleep_req(sleep_req), .core_reset_n(core_reset_n), .sleeping(sleeping),
		.brownout_monitor_en(bod_en), .brownout_trip_sel(trip), .irq(irq),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
	swb_core_model u_core (.clock(clock), .nrst(nrst), .go_sleep(go_sleep),
		.core_reset_n(core_reset_n), .sleeping(sleeping), .sleep_req(sleep_req));
	////////////////////////////////////////////////////////////////////////////
	task conclude;
		if (error_cnt == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task fail;
		error_cnt++;
		$display("[ERR] %0t wait ran out", $time);
		conclude;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one idle cycle after each access keeps a request from being set twice in a step
	task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		integer k;
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !w;
		avs_write <= w;
		k = 0;
		do begin
			@(posedge clock);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 50);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (k >= 50) fail;
		@(posedge clock);
	endtask
	task wrst(input logic v);
		integer k;
		for (k = 0; core_reset_n !== v; k++) begin
			if (k == 400) fail;
			@(posedge clock);
		end
	endtask
	// only the four unmasked passes may raise the line; pass 2 runs with the mask clear
	function automatic logic [31:0] exp_irq(input integer j);
		exp_irq = {31'h0, j != 2};
	endfunction
	task nap;
		go_sleep <= 1'b1;
		@(posedge clock);
		go_sleep <= 1'b0;
		repeat (3) @(posedge clock);
		chk(sleeping, 32'h1);
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge clock);
		nrst <= 1'b1;
		wrst(1'b1);
		bus(0, 5'h00, 32'h0);
		chk(rd, 32'h1);
		chk(bod_en, 32'h0);
		bus(1, 5'h14, $random(seed));
		bus(0, 5'h14, 32'h0);
		chk(rd, 32'h0);
		avs_byteenable <= 4'h0;
		bus(1, 5'h00, 32'h10);
		avs_byteenable <= 4'hF;
		bus(0, 5'h00, 32'h0);
		chk(rd, 32'h1);
		bus(1, 5'h00, 32'h11);
		for (i = 0; i < 5; i++) begin
			p = (i == 4) ? 7 : i;
			bus(1, 5'h0C, exp_irq(i));
			hv <= $random(seed);
			repeat (F + 6) @(posedge clock);
			chk(core_reset_n, 32'h1);
			nap;
			hv[p] <= ~hv[p];
			@(posedge clock);
			hv[p] <= ~hv[p];
			repeat (F + 6) @(posedge clock);
			chk(sleeping, 32'h1);
			hv[p] <= ~hv[p];
			wrst(1'b0);
			for (n = 0; core_reset_n === 1'b0 && n < 99; n++) @(posedge clock);
			chk(n, W);
			bus(0, 5'h04, 32'h0);
			chk(rd, 32'h0);
			chk(irq, exp_irq(i));
			bus(0, 5'h08, 32'h0);
			chk(rd, 32'h1);
			chk(irq, 32'h0);
			bus(1, 5'h04, 32'h1);
		end
		bus(1, 5'h00, 32'h01);
		nap;
		hv <= ~hv;
		repeat (F + 10) @(posedge clock);
		chk(sleeping, 32'h1);
		ext_n <= 1'b0;
		repeat (12) @(posedge clock);
		chk({sleeping, core_reset_n}, 32'h0);
		ext_n <= 1'b1;
		wrst(1'b1);
		supply_low <= 1'b1;
		repeat (F + 10) @(posedge clock);
		chk(core_reset_n, 32'h1);
		bus(1, 5'h00, 32'h0);
		chk(bod_en, 32'h1);
		wrst(1'b0);
		repeat (20) @(posedge clock);
		chk(core_reset_n, 32'h0);
		supply_low <= 1'b0;
		wrst(1'b1);
		bus(0, 5'h08, 32'h0);
		chk(rd, 32'h2);
		bus(1, 5'h10, 32'hA5);
		bus(1, 5'h00, 32'h2);
		chk(trip, 32'h0);
		bus(1, 5'h00, 32'h1);
		bus(1, 5'h00, 32'h3);
		chk(trip, 32'h0);
		bus(1, 5'h10, 32'hA5);
		bus(1, 5'h00, 32'h3);
		chk(trip, 32'h1);
		bus(1, 5'h10, 32'h5A);
		bus(1, 5'h00, 32'h1);
		bus(0, 5'h00, 32'h0);
		chk(rd, 32'h3);
		conclude;
	end
endmodule
`default_nettype wire
